// *** core/uhpc_hub_port_control.sv ***
/*
 * Hub register logic behind APB: endpoint status, global state, hub status, ports.
 * Assumes one-cycle event pulses, all synchronous to core_clk_in.
 */
// The APB interface to the registers is this design's own decision.
// Operation
// - Host ACK, or any isochronous send, clears transmit-ready.
// - Hardware clearing transmit-ready with interrupt enabled raises interrupt.
// - Writing one to stall clear bit clears stall-sent status bit 3.
// - Writing one to out clear bit clears received-OUT status bit 1.
// - Writing one to in clear bit clears transmit-complete status bit 0.
// - Reserved bits always read as zero.
// - Hub endpoint 1 in hardware: report changes at next IN, else NAK.
// - Hub control endpoint uses the same handshake as function control endpoint.
// - Suspended flag bit 4 follows hardware suspend state, read-only.
// - Resume flag bit 3 set on upstream resume until downstream resume done.
// - Remote wake enable bit 2 set when host enables remote wakeup.
// - Configured bit 1 set by firmware, cleared on reset or config zero.
// - Address valid bit 0 makes hub use new address from next transaction.
// - Hub status: bit3 overcurrent change, bit2 power change, bit1 overcurrent, bit0 lost.
// - Bitmap bit 0 is one whenever hub status bit 1 or 3 is one.
// - Command bits 6:4 decode disable, enable, reset, suspend, resume.
// - Disable/enable moves addressed downstream port; port 1 left to firmware.
// - Reset-and-enable drives reset signalling on addressed port, then enables it.
// - Suspend idles the addressed port and stops forwarding traffic.
// - Resume sends resume signalling on addressed port, then enables it.
// - Port select bits 2:0 choose port; 3 selects port 3, 2 port 2.
// - After reset signalling ends, hardware sets the port's reset-complete change bit.
`timescale 1ns/1ps
`include "uhpc_params.svh"

module uhpc_hub_port_control
    import uhpc_pkg::*;
#(
    parameter int unsigned RESET_SIG_CYCLES =
        `UHPC_RESET_SIG_MS * `UHPC_CLK_MHZ * 1000,
    parameter int unsigned RESUME_SIG_CYCLES =
        `UHPC_RESUME_SIG_MS * `UHPC_CLK_MHZ * 1000
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire uhpc_ep_event_t [2:0] ep_event_in,
    input wire logic [2:0] ep_int_en_in,
    input wire logic usb_suspended_in,
    input wire logic upstream_resume_in,
    input wire logic downstream_resume_done_in,
    input wire logic host_rwake_set_in,
    input wire logic host_rwake_clr_in,
    input wire logic host_config_zero_in,
    input wire logic hub_ep1_in_token_in,
    input wire logic [2:0] port_change_in,
    output logic [2:0] ep_tx_ready_out,
    output logic ep_int_out,
    output logic hub_ep1_ack_out,
    output logic hub_ep1_nak_out,
    output logic [7:0] hub_ep1_bitmap_out,
    output logic hub_addr_valid_out,
    output logic [1:0] port_enabled_out,
    output logic [1:0] port_reset_drive_out,
    output logic [1:0] port_suspended_out,
    output logic [1:0] port_resume_drive_out,
    output logic [1:0] reset_complete_change_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction

    function automatic int ep_index(input logic [15:0] a, input logic [15:0] base);
        if (a == base) ep_index = 0;
        else if (a == base + 16'h0004) ep_index = 1;
        else if (a == base + 16'h0008) ep_index = 2;
        else ep_index = -1;
    endfunction

    // ------------------------------------------------------------------
    // APB access strobes
    // ------------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wbyte;
    int ack_idx;
    int st_idx;

    always_comb begin
        wr_acc = psel_in && penable_in && pwrite_in && !pready_out;
        rd_acc = psel_in && penable_in && !pwrite_in && !pready_out;
        wbyte = pwdata_in[7:0];
        ack_idx = ep_index(paddr_in, `UHPC_ADDR_EP_ACK1);
        st_idx = ep_index(paddr_in, `UHPC_ADDR_EP_STATUS1);
    end

    // ------------------------------------------------------------------
    // Endpoint acknowledge and status
    // ------------------------------------------------------------------
    logic [2:0][7:0] ack_ff;
    logic [2:0][7:0] nxt_ack;
    logic [2:0][3:0] est_ff;
    logic [2:0][3:0] nxt_est;
    logic ep_int_ff;
    logic nxt_ep_int;

    always_comb begin
        nxt_ack = ack_ff;
        nxt_est = est_ff;
        nxt_ep_int = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (wr_acc && ack_idx == i) begin
                // Clear strobes are not stored
                nxt_ack[i] = wbyte & `UHPC_ACK_WMASK;
                if (wbyte[`UHPC_ACK_STALL_CLR])
                    nxt_est[i][`UHPC_ST_STALL_SENT] = 1'b0;
                if (wbyte[`UHPC_ACK_OUT_CLR])
                    nxt_est[i][`UHPC_ST_OUT_RCVD] = 1'b0;
                if (wbyte[`UHPC_ACK_IN_CLR])
                    nxt_est[i][`UHPC_ST_TX_DONE] = 1'b0;
            end
            // Hardware sets win over clears
            if (ep_event_in[i].stall_sent)
                nxt_est[i][`UHPC_ST_STALL_SENT] = 1'b1;
            if (ep_event_in[i].out_rcvd)
                nxt_est[i][`UHPC_ST_OUT_RCVD] = 1'b1;
            if ((ep_event_in[i].tx_acked || ep_event_in[i].iso_sent)
                    && ack_ff[i][`UHPC_ACK_TX_READY]) begin
                nxt_ack[i][`UHPC_ACK_TX_READY] = 1'b0;
                nxt_est[i][`UHPC_ST_TX_DONE] = 1'b1;
                if (ep_int_en_in[i])
                    nxt_ep_int = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ack_ff <= '0;
            est_ff <= '0;
            ep_int_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
            est_ff <= nxt_est;
            ep_int_ff <= nxt_ep_int;
        end
    end

    // ------------------------------------------------------------------
    // Global state and hub status
    // ------------------------------------------------------------------
    logic [7:0] gs_ff;
    logic [7:0] nxt_gs;
    logic [7:0] hs_ff;
    logic [7:0] nxt_hs;
    logic hs_pending_ff;
    logic nxt_hs_pending;
    logic [7:0] bitmap;
    logic [1:0] rcc_ff;
    logic [1:0] nxt_rcc;

    always_comb begin
        nxt_gs = gs_ff;
        nxt_hs = hs_ff;
        if (host_config_zero_in)
            nxt_gs[`UHPC_GS_CONFIG] = 1'b0;
        if (host_rwake_clr_in)
            nxt_gs[`UHPC_GS_RWAKE] = 1'b0;
        if (wr_acc && paddr_in == `UHPC_ADDR_GLOBAL_STATE)
            nxt_gs = (gs_ff & ~`UHPC_GS_WMASK) | (wbyte & `UHPC_GS_WMASK);
        if (host_rwake_set_in)
            nxt_gs[`UHPC_GS_RWAKE] = 1'b1;
        nxt_gs[`UHPC_GS_SUSPENDED] = usb_suspended_in;
        if (downstream_resume_done_in)
            nxt_gs[`UHPC_GS_RESUME] = 1'b0;
        if (upstream_resume_in)
            nxt_gs[`UHPC_GS_RESUME] = 1'b1;
        nxt_gs[7:5] = 3'h0;
        if (wr_acc && paddr_in == `UHPC_ADDR_HUB_STATUS)
            nxt_hs = wbyte & `UHPC_HS_WMASK;
    end

    always_comb begin
        bitmap = 8'h00;
        bitmap[0] = hs_ff[`UHPC_HS_OC_IND] | hs_ff[`UHPC_HS_OC_CHANGE];
        bitmap[3:1] = port_change_in;
    end

    // Hub change waiting for the next IN
    always_comb begin
        nxt_hs_pending = hs_pending_ff;
        if (hub_ep1_in_token_in)
            nxt_hs_pending = 1'b0;
        if (nxt_hs != hs_ff || nxt_rcc != rcc_ff || |port_change_in)
            nxt_hs_pending = 1'b1;
    end

    // ------------------------------------------------------------------
    // Port control: ports 2 and 3 only; port 1 handled by firmware
    // ------------------------------------------------------------------
    logic [7:0] pc_ff;
    logic [7:0] nxt_pc;
    uhpc_port_state_t [1:0] pst_ff;
    uhpc_port_state_t [1:0] nxt_pst;
    logic [1:0][31:0] tmr_ff;
    logic [1:0][31:0] nxt_tmr;
    uhpc_cmd_t cmd;
    logic [2:0] sel;

    always_comb begin
        nxt_pc = pc_ff;
        nxt_pst = pst_ff;
        nxt_tmr = tmr_ff;
        nxt_rcc = rcc_ff;
        cmd = uhpc_cmd_t'(wbyte[`UHPC_PC_CMD_LSB +: 3]);
        sel = wbyte[`UHPC_PC_SEL_LSB +: 3];
        for (int p = 0; p < 2; p++) begin
            if (tmr_ff[p] != 32'h0)
                nxt_tmr[p] = tmr_ff[p] - 32'h1;
            case (pst_ff[p])
                UHPC_PS_RESETTING: begin
                    if (tmr_ff[p] == 32'h1)
                        nxt_pst[p] = UHPC_PS_ENABLED;
                end
                UHPC_PS_RESUMING: begin
                    if (tmr_ff[p] == 32'h1)
                        nxt_pst[p] = UHPC_PS_ENABLED;
                end
                default: begin
                end
            endcase
        end
        if (wr_acc && paddr_in == `UHPC_ADDR_PORT_CONTROL) begin
            nxt_pc = wbyte & `UHPC_PC_WMASK;
            for (int p = 0; p < 2; p++) begin
                if (sel == 3'(p + 2)) begin
                    case (cmd)
                        UHPC_CMD_DISABLE: nxt_pst[p] = UHPC_PS_DISABLED;
                        UHPC_CMD_ENABLE: nxt_pst[p] = UHPC_PS_ENABLED;
                        UHPC_CMD_RESET: begin
                            nxt_pst[p] = UHPC_PS_RESETTING;
                            nxt_tmr[p] = RESET_SIG_CYCLES;
                        end
                        UHPC_CMD_SUSPEND: nxt_pst[p] = UHPC_PS_SUSPENDED;
                        UHPC_CMD_RESUME: begin
                            nxt_pst[p] = UHPC_PS_RESUMING;
                            nxt_tmr[p] = RESUME_SIG_CYCLES;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        if (wr_acc && paddr_in == `UHPC_ADDR_PORT_STATE)
            nxt_rcc = rcc_ff & ~wbyte[5:4];
        for (int p = 0; p < 2; p++) begin
            if (pst_ff[p] == UHPC_PS_RESETTING && tmr_ff[p] == 32'h1)
                nxt_rcc[p] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            gs_ff <= `UHPC_GS_RESET;
            hs_ff <= `UHPC_HS_RESET;
            hs_pending_ff <= 1'b0;
            pc_ff <= `UHPC_PC_RESET;
            pst_ff <= '{UHPC_PS_DISABLED, UHPC_PS_DISABLED};
            tmr_ff <= '0;
            rcc_ff <= 2'h0;
        end else begin
            gs_ff <= nxt_gs;
            hs_ff <= nxt_hs;
            hs_pending_ff <= nxt_hs_pending;
            pc_ff <= nxt_pc;
            pst_ff <= nxt_pst;
            tmr_ff <= nxt_tmr;
            rcc_ff <= nxt_rcc;
        end
    end

    // ------------------------------------------------------------------
    // Hub endpoint 1 answer and port drive outputs
    // ------------------------------------------------------------------
    logic nxt_ep1_ack;
    logic nxt_ep1_nak;
    logic [7:0] nxt_bitmap;
    logic [7:0] ep1_bitmap_ff;
    logic ep1_ack_ff;
    logic ep1_nak_ff;
    logic [1:0] pen_ff;
    logic [1:0] prst_ff;
    logic [1:0] psus_ff;
    logic [1:0] pres_ff;

    always_comb begin
        nxt_ep1_ack = hub_ep1_in_token_in && hs_pending_ff;
        nxt_ep1_nak = hub_ep1_in_token_in && !hs_pending_ff;
        nxt_bitmap = nxt_ep1_ack ? (bitmap | {5'h00, rcc_ff, 1'b0})
                                 : ep1_bitmap_ff;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ep1_ack_ff <= 1'b0;
            ep1_nak_ff <= 1'b0;
            ep1_bitmap_ff <= 8'h00;
            pen_ff <= 2'h0;
            prst_ff <= 2'h0;
            psus_ff <= 2'h0;
            pres_ff <= 2'h0;
        end else begin
            ep1_ack_ff <= nxt_ep1_ack;
            ep1_nak_ff <= nxt_ep1_nak;
            ep1_bitmap_ff <= nxt_bitmap;
            for (int p = 0; p < 2; p++) begin
                pen_ff[p] <= nxt_pst[p] == UHPC_PS_ENABLED;
                prst_ff[p] <= nxt_pst[p] == UHPC_PS_RESETTING;
                psus_ff[p] <= nxt_pst[p] == UHPC_PS_SUSPENDED;
                pres_ff[p] <= nxt_pst[p] == UHPC_PS_RESUMING;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB read path and ready
    // ------------------------------------------------------------------
    logic [31:0] rdata;
    logic rerr;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    always_comb begin
        rdata = 32'h00000000;
        rerr = 1'b0;
        if (ack_idx >= 0)
            rdata = zext8(ack_ff[ack_idx[1:0]]);
        else if (st_idx >= 0)
            rdata = zext8({4'h0, est_ff[st_idx[1:0]]});
        else if (paddr_in == `UHPC_ADDR_GLOBAL_STATE)
            rdata = zext8(gs_ff);
        else if (paddr_in == `UHPC_ADDR_HUB_STATUS)
            rdata = zext8(hs_ff);
        else if (paddr_in == `UHPC_ADDR_PORT_CONTROL)
            rdata = zext8(pc_ff);
        else if (paddr_in == `UHPC_ADDR_PORT_STATE)
            rdata = zext8({2'h0, rcc_ff, 1'b0, psus_ff[1], pen_ff[1:0]});
        else if (paddr_in == `UHPC_ADDR_HUB_EP1)
            rdata = zext8(bitmap);
        else
            rerr = 1'b1;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= rd_acc ? rdata : 32'h00000000;
            pready_ff <= wr_acc || rd_acc;
            pslverr_ff <= (wr_acc || rd_acc) && rerr;
        end
    end

    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign ep_int_out = ep_int_ff;
    assign hub_ep1_ack_out = ep1_ack_ff;
    assign hub_ep1_nak_out = ep1_nak_ff;
    assign hub_ep1_bitmap_out = ep1_bitmap_ff;
    assign hub_addr_valid_out = gs_ff[`UHPC_GS_ADDR_VALID];
    assign port_enabled_out = pen_ff;
    assign port_reset_drive_out = prst_ff;
    assign port_suspended_out = psus_ff;
    assign port_resume_drive_out = pres_ff;
    assign reset_complete_change_out = rcc_ff;

    always_comb begin
        for (int i = 0; i < 3; i++)
            ep_tx_ready_out[i] = ack_ff[i][`UHPC_ACK_TX_READY];
    end

endmodule

// *** core/uhpc_params.svh ***
/*
 * Offsets, field positions, reset values and signalling times of the hub block.
 * Assumes 32-bit APB byte addressing.
 */
`ifndef UHPC_PARAMS_SVH
`define UHPC_PARAMS_SVH

// Global state kept as index; byte address = index * 4
`define UHPC_IDX_GLOBAL_STATE 14'h1FFB
`define UHPC_ADDR_GLOBAL_STATE 16'h7FEC
`define UHPC_ADDR_EP_ACK1 16'h0000
`define UHPC_ADDR_EP_ACK2 16'h0004
`define UHPC_ADDR_EP_ACK3 16'h0008
`define UHPC_ADDR_EP_STATUS1 16'h0010
`define UHPC_ADDR_EP_STATUS2 16'h0014
`define UHPC_ADDR_EP_STATUS3 16'h0018
`define UHPC_ADDR_HUB_STATUS 16'h0020
`define UHPC_ADDR_PORT_CONTROL 16'h0024
`define UHPC_ADDR_PORT_STATE 16'h0028
`define UHPC_ADDR_HUB_EP1 16'h002C

// Endpoint acknowledge register fields
`define UHPC_ACK_DATA_END 6
`define UHPC_ACK_FORCE_STALL 5
`define UHPC_ACK_TX_READY 4
`define UHPC_ACK_STALL_CLR 3
`define UHPC_ACK_OUT_CLR 1
`define UHPC_ACK_IN_CLR 0
`define UHPC_ACK_WMASK 8'h70

// Endpoint status fields
`define UHPC_ST_STALL_SENT 3
`define UHPC_ST_OUT_RCVD 1
`define UHPC_ST_TX_DONE 0

// Global state fields
`define UHPC_GS_SUSPENDED 4
`define UHPC_GS_RESUME 3
`define UHPC_GS_RWAKE 2
`define UHPC_GS_CONFIG 1
`define UHPC_GS_ADDR_VALID 0
`define UHPC_GS_WMASK 8'h07
`define UHPC_GS_RESET 8'h00

// Hub status fields
`define UHPC_HS_OC_CHANGE 3
`define UHPC_HS_LP_CHANGE 2
`define UHPC_HS_OC_IND 1
`define UHPC_HS_LP_LOST 0
`define UHPC_HS_WMASK 8'h0F
`define UHPC_HS_RESET 8'h00

// Port control fields
`define UHPC_PC_CMD_LSB 4
`define UHPC_PC_SEL_LSB 0
`define UHPC_PC_WMASK 8'h77
`define UHPC_PC_RESET 8'h00

// Reset and resume signalling times
`define UHPC_RESET_SIG_MS 10
`define UHPC_RESUME_SIG_MS 20
`define UHPC_CLK_MHZ 200

`endif

// *** core/uhpc_pkg.sv ***
/*
 * Types for the hub port control block.
 * Assumes uhpc_params.svh holds the numbers.
 */
package uhpc_pkg;

    typedef enum logic [2:0] {
        UHPC_CMD_DISABLE,
        UHPC_CMD_ENABLE,
        UHPC_CMD_RESET,
        UHPC_CMD_SUSPEND,
        UHPC_CMD_RESUME
    } uhpc_cmd_t;

    typedef enum logic [2:0] {
        UHPC_PS_DISABLED,
        UHPC_PS_ENABLED,
        UHPC_PS_RESETTING,
        UHPC_PS_SUSPENDED,
        UHPC_PS_RESUMING
    } uhpc_port_state_t;

    typedef struct packed {
        logic tx_acked;
        logic iso_sent;
        logic stall_sent;
        logic out_rcvd;
    } uhpc_ep_event_t;

    typedef struct packed {
        logic [3:0] status;
        logic       tx_ready;
    } uhpc_ep_view_t;

endpackage

// *** tb/uhpc_usb_model.sv ***
/*
 * USB engine model: endpoint event pulses and hub endpoint 1 IN tokens.
 * Assumes the bench calls its tasks.
 */
`timescale 1ns/1ps
module uhpc_usb_model
    import uhpc_pkg::*;
(
    input wire logic core_clk_in,
    output uhpc_ep_event_t [2:0] ev_out,
    output logic token_out
);
    initial begin
        ev_out = '0;
        token_out = 1'b0;
    end

    // One-cycle event pulse on one endpoint
    task automatic send(input int ep, input logic [3:0] e);
        @(posedge core_clk_in);
        ev_out[ep] <= e;
        @(posedge core_clk_in);
        ev_out[ep] <= '0;
    endtask

    // IN token addressed to hub endpoint 1
    task automatic in_token();
        @(posedge core_clk_in);
        token_out <= 1'b1;
        @(posedge core_clk_in);
        token_out <= 1'b0;
    endtask
endmodule

// *** tb/uhpc_hub_port_control_asserts.sv ***
/*
 * Port-level assertions for the hub port control block.
 * Assumes signalling counts of a few dozen cycles at most.
 */
`timescale 1ns/1ps
module uhpc_hub_port_control_asserts
    import uhpc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire uhpc_ep_event_t [2:0] ep_event_in,
    input wire logic [2:0] ep_int_en_in,
    input wire logic hub_ep1_in_token_in,
    input wire logic [2:0] ep_tx_ready_out,
    input wire logic ep_int_out,
    input wire logic hub_ep1_ack_out,
    input wire logic hub_ep1_nak_out,
    input wire logic hub_addr_valid_out,
    input wire logic [1:0] port_enabled_out,
    input wire logic [1:0] port_reset_drive_out,
    input wire logic [1:0] port_resume_drive_out,
    input wire logic [1:0] reset_complete_change_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_taken;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_apb_write;
        psel_in && penable_in && pwrite_in;
    endsequence

    property p_answer;
        s_taken |=> pready_out;
    endproperty
    property p_upper_zero;
        pready_out |-> prdata_out[31:8] == 24'h000000;
    endproperty
    property p_tx_clear;
        ep_event_in[0].tx_acked |=> !ep_tx_ready_out[0];
    endproperty
    property p_int_cause;
        ep_int_out |-> $past(|(ep_int_en_in & ep_tx_ready_out));
    endproperty
    property p_ep1_answer;
        hub_ep1_in_token_in |=> hub_ep1_ack_out ^ hub_ep1_nak_out;
    endproperty
    property p_addr_write;
        $rose(hub_addr_valid_out) |-> $past(psel_in && penable_in && pwrite_in);
    endproperty
    property p_reset_end;
        $rose(port_reset_drive_out[0]) |-> ##[1:40] reset_complete_change_out[0];
    endproperty
    property p_reset_enable;
        $fell(port_reset_drive_out[0]) |-> ##[0:2] port_enabled_out[0];
    endproperty
    property p_resume_enable;
        $fell(port_resume_drive_out[1]) |-> ##[0:2] port_enabled_out[1];
    endproperty

    a_answer: assert property (p_answer) else $error("pready late");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_tx_clear: assert property (p_tx_clear) else $error("tx ready kept");
    a_int_cause: assert property (p_int_cause) else $error("stray interrupt");
    a_ep1_answer: assert property (p_ep1_answer) else $error("no ep1 answer");
    a_addr_write: assert property (p_addr_write) else $error("address valid rose");
    a_reset_end: assert property (p_reset_end) else $error("no reset change");
    a_reset_enable: assert property (p_reset_enable) else $error("not enabled");
    a_resume_enable: assert property (p_resume_enable) else $error("not resumed");
    c_write: cover property (s_apb_write);
endmodule

bind uhpc_hub_port_control uhpc_hub_port_control_asserts u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .ep_event_in(ep_event_in), .ep_int_en_in(ep_int_en_in),
    .hub_ep1_in_token_in(hub_ep1_in_token_in), .ep_tx_ready_out(ep_tx_ready_out),
    .ep_int_out(ep_int_out), .hub_ep1_ack_out(hub_ep1_ack_out),
    .hub_ep1_nak_out(hub_ep1_nak_out), .hub_addr_valid_out(hub_addr_valid_out),
    .port_enabled_out(port_enabled_out), .port_reset_drive_out(port_reset_drive_out),
    .port_resume_drive_out(port_resume_drive_out),
    .reset_complete_change_out(reset_complete_change_out));

// *** tb/usb_hub_port_control_tb.sv ***
/*
 * Self-checking APB bench for the hub port control block.
 * Assumes 8-cycle signalling counts and the USB engine model.
 */
`timescale 1ns/1ps
`include "uhpc_params.svh"
module usb_hub_port_control_tb;
    import uhpc_pkg::*;
    typedef struct {logic [15:0] a; logic [31:0] w; logic [31:0] r; logic e;} uhpc_row_t;
    logic core_clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, err, tok, ep_int, ack, nak, addr_ok, usb_susp = 1'b0;
    logic int_seen = 1'b0, ack_seen = 1'b0, nak_seen = 1'b0;
    logic [3:0] hw = 4'h0;
    uhpc_ep_event_t [2:0] ev;
    logic [2:0] txr;
    logic [7:0] bmap;
    logic [1:0] en, rdrv, susp, resd, rcc;
    int failures = 0, num_checks = 0, cyc = 0;
    uhpc_row_t rows [5] = '{
        '{`UHPC_ADDR_GLOBAL_STATE, 32'hFFFFFFFF, 32'h00000007, 1'b0},
        '{`UHPC_ADDR_GLOBAL_STATE, 32'h00000000, 32'h00000000, 1'b0},
        '{`UHPC_ADDR_HUB_STATUS, 32'hFFFFFFFF, 32'h0000000F, 1'b0},
        '{`UHPC_ADDR_HUB_STATUS, 32'h00000000, 32'h00000000, 1'b0},
        '{16'h0040, 32'hFFFFFFFF, 32'h00000000, 1'b1}};
    logic [7:0] clr [3] = '{8'h08, 8'h02, 8'h01};
    logic [7:0] left [3] = '{8'h03, 8'h01, 8'h00};

    always #2.5 core_clk_in = ~core_clk_in;

    uhpc_usb_model u_usb (.core_clk_in(core_clk_in), .ev_out(ev), .token_out(tok));

    uhpc_hub_port_control #(.RESET_SIG_CYCLES(8), .RESUME_SIG_CYCLES(8)) u_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .ep_event_in(ev), .ep_int_en_in(3'h1),
        .usb_suspended_in(usb_susp), .upstream_resume_in(hw[0]),
        .downstream_resume_done_in(hw[1]), .host_rwake_set_in(hw[2]),
        .host_rwake_clr_in(1'b0), .host_config_zero_in(hw[3]), .hub_ep1_in_token_in(tok),
        .port_change_in(3'h0), .ep_tx_ready_out(txr), .ep_int_out(ep_int),
        .hub_ep1_ack_out(ack), .hub_ep1_nak_out(nak), .hub_ep1_bitmap_out(bmap),
        .hub_addr_valid_out(addr_ok), .port_enabled_out(en), .port_reset_drive_out(rdrv),
        .port_suspended_out(susp), .port_resume_drive_out(resd),
        .reset_complete_change_out(rcc));

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // APB master: hold request until pready sampled high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        do @(posedge core_clk_in);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    task automatic pulse(input logic [3:0] m);
        @(posedge core_clk_in);
        hw <= m;
        @(posedge core_clk_in);
        hw <= 4'h0;
    endtask

    task automatic token();
        ack_seen = 1'b0;
        nak_seen = 1'b0;
        u_usb.in_token();
        repeat (2) @(posedge core_clk_in);
    endtask

    task automatic pcmd(input logic [7:0] c);
        apb(1'b1, `UHPC_ADDR_PORT_CONTROL, {24'h0, c});
        repeat (30) @(posedge core_clk_in);
    endtask

    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (ep_int === 1'b1) int_seen <= 1'b1;
        if (ack === 1'b1) ack_seen <= 1'b1;
        if (nak === 1'b1) nak_seen <= 1'b1;
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rdc("gs_reset", `UHPC_ADDR_GLOBAL_STATE, 32'h0);
        rdc("pc_reset", `UHPC_ADDR_PORT_CONTROL, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            check("slverr", {31'h0, err}, {31'h0, rows[i].e});
            rdc("reg", rows[i].a, rows[i].r);
        end
        apb(1'b1, `UHPC_ADDR_EP_ACK1, 32'h10);
        check("txr_set", {29'h0, txr}, 32'h1);
        int_seen = 1'b0;
        u_usb.send(0, 4'h8);
        repeat (2) @(posedge core_clk_in);
        check("txr_ack", {29'h0, txr}, 32'h0);
        check("int", {31'h0, int_seen}, 32'h1);
        u_usb.send(0, 4'h3);
        rdc("status", `UHPC_ADDR_EP_STATUS1, 32'h0B);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `UHPC_ADDR_EP_ACK1, {24'h0, clr[i]});
            rdc("status", `UHPC_ADDR_EP_STATUS1, {24'h0, left[i]});
        end
        rdc("ack_reg", `UHPC_ADDR_EP_ACK1, 32'h0);
        apb(1'b1, `UHPC_ADDR_EP_ACK2, 32'h10);
        int_seen = 1'b0;
        u_usb.send(1, 4'h4);
        repeat (2) @(posedge core_clk_in);
        check("txr_iso", {29'h0, txr}, 32'h0);
        check("int_off", {31'h0, int_seen}, 32'h0);
        token();
        token();
        check("nak", {31'h0, nak_seen}, 32'h1);
        apb(1'b1, `UHPC_ADDR_HUB_STATUS, 32'h02);
        token();
        check("ack", {31'h0, ack_seen}, 32'h1);
        check("bitmap0", {31'h0, bmap[0]}, 32'h1);
        usb_susp <= 1'b1;
        rdc("gs_susp", `UHPC_ADDR_GLOBAL_STATE, 32'h10);
        usb_susp <= 1'b0;
        pulse(4'h1);
        rdc("gs_resume", `UHPC_ADDR_GLOBAL_STATE, 32'h08);
        pulse(4'h2);
        rdc("gs_done", `UHPC_ADDR_GLOBAL_STATE, 32'h00);
        pulse(4'h4);
        rdc("gs_rwake", `UHPC_ADDR_GLOBAL_STATE, 32'h04);
        apb(1'b1, `UHPC_ADDR_GLOBAL_STATE, 32'h07);
        check("addr_ok", {31'h0, addr_ok}, 32'h1);
        pulse(4'h8);
        rdc("gs_cfg0", `UHPC_ADDR_GLOBAL_STATE, 32'h05);
        pcmd(8'h22);
        check("en", {30'h0, en}, 32'h1);
        check("rcc", {30'h0, rcc}, 32'h1);
        pcmd(8'h13);
        check("en", {30'h0, en}, 32'h3);
        pcmd(8'h33);
        check("susp", {30'h0, susp}, 32'h2);
        pcmd(8'h43);
        check("susp", {30'h0, susp}, 32'h0);
        check("en", {30'h0, en}, 32'h3);
        pcmd(8'h02);
        check("en", {30'h0, en}, 32'h2);
        pcmd(8'h01);
        check("en", {30'h0, en}, 32'h2);
        end_sim();
    end
endmodule
